// >>> logic/ccrl_pkg.sv
// Package with register map, field positions and shared types of the control/reset block
package ccrl_pkg;
    // Register map (byte addresses)
    localparam logic [31:0] CTRL_ADDR    = 32'h0000_0000;
    localparam logic [31:0] CMD_ADDR     = 32'h0000_0004;
    localparam logic [31:0] IRQ_ADDR     = 32'h0000_0008;
    localparam logic [31:0] STAT_ADDR    = 32'h0000_000C;
    localparam logic [31:0] RXSTART_ADDR = 32'h0000_0010;

    // Control field positions
    localparam int RR_BIT   = 0;
    localparam int RIE_BIT  = 1;
    localparam int TIE_BIT  = 2;
    localparam int EIE_BIT  = 3;
    localparam int OIE_BIT  = 4;
    localparam int ONE_BIT  = 5;
    localparam int SPARE_BIT = 6;
    localparam int RSVD_BIT  = 7;

    // Interrupt flag positions
    localparam int IRQ_RX  = 0;
    localparam int IRQ_TX  = 1;
    localparam int IRQ_ERR = 2;
    localparam int IRQ_OVR = 3;

    localparam logic [7:0]  CMD_READBACK = 8'hFF;
    localparam logic [7:0]  IRQ_RSVD     = 8'hE0;
    localparam logic [1:0]  RESP_OKAY    = 2'b00;
    localparam logic [1:0]  RESP_SLVERR  = 2'b10;

    // Bus-free sequence counts
    localparam int BUSFREE_BITS    = 11;
    localparam int BUSOFF_RECOVERS = 128;

    localparam logic [7:0] PTR_ZERO = 8'h00;

    typedef enum logic [1:0] {
        CCRL_RESET,
        CCRL_WAIT_FREE,
        CCRL_BUS_ON
    } ccrl_mode_t;

    // Events reported by the protocol engine
    typedef struct packed {
        logic rx_ok;
        logic tx_done;
        logic tx_released;
        logic overrun;
        logic err_status;
        logic bus_off;
        logic recessive_bit;
    } ccrl_evt_t;
endpackage

// >>> logic/ccrl_top.sv
// Control register, reset-mode sequencing and AXI4-Lite slave of the CAN controller
//
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/1ns
module ccrl_top #(
    parameter int PTR_W = 8
) (
    input  wire logic                 ref_clk,
    input  wire logic                 rstn,
    input  wire logic                 clk_en,
    input  wire logic                 ext_reset_n,
    input  wire ccrl_pkg::ccrl_evt_t  evt,
    input  wire logic                 tx_in_progress,
    input  wire logic                 rx_in_progress,
    input  wire logic [PTR_W-1:0]     fifo_start,
    input  wire logic [31:0]          s_axi_awaddr,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    output logic [1:0]                s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    input  wire logic [31:0]          s_axi_araddr,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    output logic [31:0]               s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    output logic                      reset_mode,
    output logic                      bus_on,
    output logic                      frame_abort,
    output logic [PTR_W-1:0]          rd_ptr,
    output logic [PTR_W-1:0]          wr_ptr,
    output logic                      tx_copy_to_rx,
    output logic                      rx_buf_lock,
    output logic [7:0]                command_strobe_reg,
    output logic                      command_valid,
    output logic                      irq_out
);

    // ========================================================
    // State
    // ========================================================
    logic                    reset_request;
    logic                    overrun_irq_en;
    logic                    error_irq_en;
    logic                    transmit_irq_en;
    logic                    receive_irq_en;
    logic                    spare_bit;
    logic                    ctrl_b7;
    logic                    cause_busoff;
    ccrl_pkg::ccrl_mode_t    mode;
    logic [3:0]              bit_cnt;
    logic [7:0]              free_cnt;
    logic [3:0]              irq_flags;
    logic                    err_prev;
    logic                    busoff_prev;
    logic                    aw_hold;
    logic                    w_hold;
    logic [31:0]             aw_addr;
    logic [31:0]             w_data;
    logic [3:0]              w_strb;

    logic                    next_reset_request;
    logic                    next_overrun_irq_en;
    logic                    next_error_irq_en;
    logic                    next_transmit_irq_en;
    logic                    next_receive_irq_en;
    logic                    next_spare_bit;
    logic                    next_ctrl_b7;
    logic                    next_cause_busoff;
    ccrl_pkg::ccrl_mode_t    next_mode;
    logic [3:0]              next_bit_cnt;
    logic [7:0]              next_free_cnt;
    logic [3:0]              next_irq_flags;
    logic [PTR_W-1:0]        next_rd_ptr;
    logic [PTR_W-1:0]        next_wr_ptr;
    logic                    next_aw_hold;
    logic                    next_w_hold;
    logic [31:0]             next_aw_addr;
    logic [31:0]             next_w_data;
    logic [3:0]              next_w_strb;
    logic                    next_bvalid;
    logic [1:0]              next_bresp;
    logic                    next_rvalid;
    logic [31:0]             next_rdata;
    logic [1:0]              next_rresp;
    logic [7:0]              next_cmd;
    logic                    next_cmd_valid;

    logic                    wr_fire;
    logic                    rd_fire;
    logic [7:0]              ctrl_rd;
    logic [7:0]              wbyte;
    logic                    rr_rise;

    // ========================================================
    // Register read views
    // ========================================================
    always_comb
    begin
        ctrl_rd                      = '0;
        ctrl_rd[ccrl_pkg::RSVD_BIT]  = ctrl_b7;
        ctrl_rd[ccrl_pkg::SPARE_BIT] = spare_bit;
        ctrl_rd[ccrl_pkg::ONE_BIT]   = 1'b1;
        ctrl_rd[ccrl_pkg::OIE_BIT]   = overrun_irq_en;
        ctrl_rd[ccrl_pkg::EIE_BIT]   = error_irq_en;
        ctrl_rd[ccrl_pkg::TIE_BIT]   = transmit_irq_en;
        ctrl_rd[ccrl_pkg::RIE_BIT]   = receive_irq_en;
        ctrl_rd[ccrl_pkg::RR_BIT]    = reset_request;
    end

    assign s_axi_awready = !aw_hold && !s_axi_bvalid;
    assign s_axi_wready  = !w_hold && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign wr_fire = (aw_hold || (s_axi_awvalid && s_axi_awready))
                  && (w_hold || (s_axi_wvalid && s_axi_wready)) && !s_axi_bvalid;
    assign rd_fire = s_axi_arvalid && s_axi_arready;
    assign wbyte   = w_hold ? w_data[7:0] : s_axi_wdata[7:0];
    assign rr_rise = next_reset_request && !reset_request;

    // ========================================================
    // Next-state logic
    // ========================================================
    always_comb
    begin
        logic [31:0] wa;
        logic        wb0;
        wa = aw_hold ? aw_addr : s_axi_awaddr;
        wb0 = w_hold ? w_strb[0] : s_axi_wstrb[0];
        next_aw_hold   = aw_hold;
        next_w_hold    = w_hold;
        next_aw_addr   = aw_addr;
        next_w_data    = w_data;
        next_w_strb    = w_strb;
        next_bvalid    = s_axi_bvalid && !s_axi_bready;
        next_bresp     = s_axi_bresp;
        next_rvalid    = s_axi_rvalid && !s_axi_rready;
        next_rdata     = s_axi_rdata;
        next_rresp     = s_axi_rresp;
        next_cmd       = command_strobe_reg;
        next_cmd_valid = 1'b0;
        next_reset_request   = reset_request;
        next_overrun_irq_en  = overrun_irq_en;
        next_error_irq_en    = error_irq_en;
        next_transmit_irq_en = transmit_irq_en;
        next_receive_irq_en  = receive_irq_en;
        next_spare_bit       = spare_bit;
        next_ctrl_b7         = ctrl_b7;
        next_cause_busoff    = cause_busoff;
        next_irq_flags       = irq_flags;
        next_rd_ptr          = rd_ptr;
        next_wr_ptr          = wr_ptr;
        next_mode            = mode;
        next_bit_cnt         = bit_cnt;
        next_free_cnt        = free_cnt;

        if (s_axi_awvalid && s_axi_awready && !wr_fire)
        begin
            next_aw_hold = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready && !wr_fire)
        begin
            next_w_hold = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end

        // Software writes
        if (wr_fire)
        begin
            next_aw_hold = 1'b0;
            next_w_hold  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = ccrl_pkg::RESP_OKAY;
            if (wa == ccrl_pkg::CTRL_ADDR)
            begin
                if (wb0)
                begin
                    next_ctrl_b7         = wbyte[ccrl_pkg::RSVD_BIT];
                    next_spare_bit       = wbyte[ccrl_pkg::SPARE_BIT];
                    next_overrun_irq_en  = wbyte[ccrl_pkg::OIE_BIT];
                    next_error_irq_en    = wbyte[ccrl_pkg::EIE_BIT];
                    next_transmit_irq_en = wbyte[ccrl_pkg::TIE_BIT];
                    next_receive_irq_en  = wbyte[ccrl_pkg::RIE_BIT];
                    if (wbyte[ccrl_pkg::RR_BIT])
                    begin
                        next_reset_request = 1'b1;
                        next_cause_busoff  = 1'b0;
                    end
                    else if (ext_reset_n)
                        next_reset_request = 1'b0;
                end
            end
            else if (wa == ccrl_pkg::CMD_ADDR)
            begin
                if (wb0)
                begin
                    next_cmd       = wbyte;
                    next_cmd_valid = 1'b1;
                end
            end
            else if (wa == ccrl_pkg::IRQ_ADDR)
            begin
                if (wb0)
                    next_irq_flags = irq_flags & ~wbyte[3:0];
            end
            else
                next_bresp = ccrl_pkg::RESP_SLVERR;
        end

        // Hardware forces of reset request
        if (!ext_reset_n)
        begin
            next_reset_request = 1'b1;
            next_cause_busoff  = 1'b0;
        end
        if (evt.bus_off)
        begin
            next_reset_request = 1'b1;
            next_cause_busoff  = 1'b1;
        end

        // Pointer reset on entering reset mode; the reset pin gives location zero
        if (next_reset_request && !reset_request)
        begin
            next_rd_ptr = !ext_reset_n ? ccrl_pkg::PTR_ZERO[PTR_W-1:0] : fifo_start;
            next_wr_ptr = !ext_reset_n ? ccrl_pkg::PTR_ZERO[PTR_W-1:0] : fifo_start;
        end

        // Mode sequencing
        case (mode)
            ccrl_pkg::CCRL_RESET:
            begin
                if (!next_reset_request)
                begin
                    next_mode     = ccrl_pkg::CCRL_WAIT_FREE;
                    next_bit_cnt  = '0;
                    next_free_cnt = '0;
                end
            end
            ccrl_pkg::CCRL_WAIT_FREE:
            begin
                if (evt.recessive_bit)
                begin
                    if (bit_cnt == 4'(ccrl_pkg::BUSFREE_BITS - 1))
                    begin
                        next_bit_cnt  = '0;
                        next_free_cnt = free_cnt + 8'h01;
                        if (!cause_busoff)
                            next_mode = ccrl_pkg::CCRL_BUS_ON;
                        else if (free_cnt == 8'(ccrl_pkg::BUSOFF_RECOVERS - 1))
                            next_mode = ccrl_pkg::CCRL_BUS_ON;
                    end
                    else
                        next_bit_cnt = bit_cnt + 4'h1;
                end
                else if (tx_in_progress || rx_in_progress)
                    next_bit_cnt = '0;
            end
            ccrl_pkg::CCRL_BUS_ON:
            begin
            end
            default:
                next_mode = ccrl_pkg::CCRL_RESET;
        endcase
        if (next_reset_request)
            next_mode = ccrl_pkg::CCRL_RESET;

        // Interrupt flags: set wins over clear
        if (receive_irq_en && evt.rx_ok)
            next_irq_flags[ccrl_pkg::IRQ_RX] = 1'b1;
        if (transmit_irq_en && (evt.tx_done || evt.tx_released))
            next_irq_flags[ccrl_pkg::IRQ_TX] = 1'b1;
        if (error_irq_en && ((evt.err_status != err_prev)
                          || (evt.bus_off != busoff_prev)))
            next_irq_flags[ccrl_pkg::IRQ_ERR] = 1'b1;
        if (error_irq_en && evt.bus_off && !busoff_prev)
            next_irq_flags[ccrl_pkg::IRQ_ERR] = 1'b1;
        if (overrun_irq_en && evt.overrun)
            next_irq_flags[ccrl_pkg::IRQ_OVR] = 1'b1;

        // Software reads
        if (rd_fire)
        begin
            next_rvalid = 1'b1;
            next_rresp  = ccrl_pkg::RESP_OKAY;
            next_rdata  = '0;
            if (s_axi_araddr == ccrl_pkg::CTRL_ADDR)
                next_rdata[7:0] = ctrl_rd;
            else if (s_axi_araddr == ccrl_pkg::CMD_ADDR)
                next_rdata[7:0] = ccrl_pkg::CMD_READBACK;
            else if (s_axi_araddr == ccrl_pkg::IRQ_ADDR)
                next_rdata[7:0] = ccrl_pkg::IRQ_RSVD | {4'h0, irq_flags};
            else if (s_axi_araddr == ccrl_pkg::STAT_ADDR)
                next_rdata[7:0] = {5'h00, cause_busoff, bus_on, reset_mode};
            else if (s_axi_araddr == ccrl_pkg::RXSTART_ADDR)
                next_rdata[PTR_W-1:0] = rd_ptr;
            else
                next_rresp = ccrl_pkg::RESP_SLVERR;
        end
    end

    // ========================================================
    // Outputs
    // ========================================================
    assign reset_mode    = (mode == ccrl_pkg::CCRL_RESET);
    assign bus_on        = (mode == ccrl_pkg::CCRL_BUS_ON);
    assign frame_abort   = rr_rise && clk_en;
    assign tx_copy_to_rx = evt.tx_done;
    assign rx_buf_lock   = evt.rx_ok;
    assign irq_out       = |irq_flags;

    // ========================================================
    // Registers
    // ========================================================
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            reset_request      <= 1'b1;
            overrun_irq_en     <= 1'b0;
            error_irq_en       <= 1'b0;
            transmit_irq_en    <= 1'b0;
            receive_irq_en     <= 1'b0;
            ctrl_b7            <= 1'b0;
            cause_busoff       <= 1'b0;
            mode               <= ccrl_pkg::CCRL_RESET;
            bit_cnt            <= '0;
            free_cnt           <= '0;
            irq_flags          <= '0;
            err_prev           <= 1'b0;
            busoff_prev        <= 1'b0;
            rd_ptr             <= '0;
            wr_ptr             <= '0;
            aw_hold            <= 1'b0;
            w_hold             <= 1'b0;
            aw_addr            <= '0;
            w_data             <= '0;
            w_strb             <= '0;
            s_axi_bvalid       <= 1'b0;
            s_axi_bresp        <= '0;
            s_axi_rvalid       <= 1'b0;
            s_axi_rdata        <= '0;
            s_axi_rresp        <= '0;
            command_strobe_reg <= '0;
            command_valid      <= 1'b0;
        end
        else if (clk_en)
        begin
            reset_request      <= next_reset_request;
            overrun_irq_en     <= next_overrun_irq_en;
            error_irq_en       <= next_error_irq_en;
            transmit_irq_en    <= next_transmit_irq_en;
            receive_irq_en     <= next_receive_irq_en;
            ctrl_b7            <= next_ctrl_b7;
            cause_busoff       <= next_cause_busoff;
            mode               <= next_mode;
            bit_cnt            <= next_bit_cnt;
            free_cnt           <= next_free_cnt;
            irq_flags          <= next_irq_flags;
            err_prev           <= evt.err_status;
            busoff_prev        <= evt.bus_off;
            rd_ptr             <= next_rd_ptr;
            wr_ptr             <= next_wr_ptr;
            aw_hold            <= next_aw_hold;
            w_hold             <= next_w_hold;
            aw_addr            <= next_aw_addr;
            w_data             <= next_w_data;
            w_strb             <= next_w_strb;
            s_axi_bvalid       <= next_bvalid;
            s_axi_bresp        <= next_bresp;
            s_axi_rvalid       <= next_rvalid;
            s_axi_rdata        <= next_rdata;
            s_axi_rresp        <= next_rresp;
            command_strobe_reg <= next_cmd;
            command_valid      <= next_cmd_valid;
        end
    end

    // Spare control bit is outside every reset
    always_ff @(posedge ref_clk)
    begin
        if (clk_en)
            spare_bit <= next_spare_bit;
    end

endmodule // ccrl_top

// >>> tb/ccrl_host.sv
// Host model that masters the register bus
`timescale 1ns/1ns
// ========
// Host
module ccrl_host (
    input wire logic ref_clk,
    output logic [31:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    output logic [31:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready
);
    initial {s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_wstrb, s_axi_awvalid,
        s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    task automatic wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge ref_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= (a == ccrl_pkg::CTRL_ADDR) ? (d & 32'h0000_007F) : d;
        s_axi_wstrb <= 4'h1;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do
        begin
            @(posedge ref_clk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end
        while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge ref_clk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do
        begin
            @(posedge ref_clk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end
        while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
endmodule // ccrl_host

// >>> tb/ccrl_sva.sv
// Concurrent checks on the control and reset block ports
`timescale 1ns/1ns
// ========
// Checker
module ccrl_sva #(
    parameter int PTR_W = 8
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic ext_reset_n,
    input wire ccrl_pkg::ccrl_evt_t evt,
    input wire logic reset_mode,
    input wire logic bus_on,
    input wire logic frame_abort,
    input wire logic [PTR_W-1:0] rd_ptr,
    input wire logic [PTR_W-1:0] wr_ptr,
    input wire logic [PTR_W-1:0] fifo_start,
    input wire logic tx_copy_to_rx,
    input wire logic rx_buf_lock
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    int unsigned nrec;
    int unsigned next_nrec;
    // Recessive bits seen since leaving reset mode
    always_comb next_nrec = reset_mode ? 0 : nrec + 32'(evt.recessive_bit);
    always_ff @(posedge ref_clk or negedge rstn)
        if (!rstn)
            nrec <= 0;
        else
            nrec <= next_nrec;
    mode_excl_a: assert property (!(reset_mode && bus_on)) else $error("mode clash");
    busoff_rr_a: assert property (evt.bus_off |-> ##[1:3] reset_mode) else $error("bus-off");
    pin_reset_a: assert property (!ext_reset_n |-> ##[1:3] reset_mode) else $error("pin");
    abort_mode_a: assert property (frame_abort |-> ##[1:3] reset_mode) else $error("abort");
    ptr_init_a: assert property ($rose(reset_mode) && $past(ext_reset_n)
        |-> rd_ptr == $past(fifo_start) && wr_ptr == $past(fifo_start)) else $error("pointers");
    leave_wait_a: assert property ($fell(reset_mode) |-> !bus_on) else $error("leave");
    bus_free_a: assert property ($rose(bus_on) |-> nrec >= 11) else $error("bus free");
    tx_copy_a: assert property (tx_copy_to_rx == evt.tx_done && rx_buf_lock == evt.rx_ok)
        else $error("copy");
    cover property ($rose(bus_on));
    cover property ($rose(reset_mode));
    cover property (evt.bus_off && !bus_on);
endmodule // ccrl_sva

bind ccrl_top ccrl_sva #(.PTR_W(PTR_W)) u_sva (.ref_clk, .rstn, .ext_reset_n, .evt, .reset_mode,
    .bus_on, .frame_abort, .rd_ptr, .wr_ptr, .fifo_start, .tx_copy_to_rx, .rx_buf_lock);

// >>> tb/tb.sv
// Self-checking bench for the control and reset block
`timescale 1ns/1ns
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_count++; \
    $display("FAIL t=%0t got %h exp %h", $time, g, e); end end
// ========
// Bench top
module tb;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic ext_reset_n = 1'b1;
    logic [7:0] fifo_start = 8'h01;
    ccrl_pkg::ccrl_evt_t evt = '0;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, reset_mode, bus_on, irq_out;
    logic [7:0] rd_ptr, cmd;
    logic [1:0] busy = 2'b00;
    logic cmd_v;
    int n_cmd = 0;
    int err_count = 0;
    int n_compared = 0;
    int ev[5] = '{6, 5, 4, 2, 3};
    int fl[5] = '{0, 1, 1, 2, 3};
    always #5 ref_clk = ~ref_clk;
    ccrl_top #(.PTR_W(8)) dut (.ref_clk, .rstn, .clk_en(1'b1), .ext_reset_n, .evt,
        .tx_in_progress(busy[1]), .rx_in_progress(busy[0]), .fifo_start, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .reset_mode, .bus_on,
        .frame_abort(), .rd_ptr, .wr_ptr(), .tx_copy_to_rx(), .rx_buf_lock(),
        .command_strobe_reg(cmd), .command_valid(cmd_v), .irq_out);
    // Count command strobes
    always @(posedge ref_clk)
        if (cmd_v)
            n_cmd <= n_cmd + 1;
    ccrl_host host (.ref_clk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready);
    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // One-cycle event pulses, then settle
    task automatic pulse(input int i, input int n);
        repeat (n)
        begin
            @(posedge ref_clk);
            evt[i] <= 1'b1;
            @(posedge ref_clk);
            evt[i] <= 1'b0;
        end
        @(posedge ref_clk);
        @(negedge ref_clk);
    endtask
    initial
    begin
        #100_000;
        err_count++;
        finish_test();
    end
    initial
    begin
        void'($urandom(65810));
        repeat (20) @(posedge ref_clk);
        rstn <= 1'b1;
        `CHK(rd_ptr, 8'h00)
        host.rd(ccrl_pkg::CTRL_ADDR, d, r);
        `CHK(d[5:0], 6'h21)
        ext_reset_n <= 1'b0;
        host.wr(ccrl_pkg::CTRL_ADDR, 32'h0000_005E, r);
        host.rd(ccrl_pkg::CTRL_ADDR, d, r);
        `CHK(d, 32'h0000_007F)
        ext_reset_n <= 1'b1;
        host.wr(ccrl_pkg::CTRL_ADDR, 32'h0000_005E, r);
        host.rd(ccrl_pkg::CTRL_ADDR, d, r);
        `CHK(d, 32'h0000_007E)
        `CHK(reset_mode, 1'b0)
        pulse(0, 10);
        `CHK(bus_on, 1'b0)
        @(posedge ref_clk);
        busy <= 2'($urandom_range(3, 1));
        @(posedge ref_clk);
        busy <= 2'b00;
        pulse(0, 10);
        `CHK(bus_on, 1'b0)
        pulse(0, 1);
        `CHK(bus_on, 1'b1)
        repeat (2)
        begin
            d = $urandom;
            host.wr(ccrl_pkg::CMD_ADDR, d, r);
        end
        @(negedge ref_clk);
        `CHK(cmd, d[7:0])
        `CHK(n_cmd, 2)
        host.rd(ccrl_pkg::CMD_ADDR, d, r);
        `CHK(d, 32'h0000_00FF)
        host.rd(32'h0000_0040, d, r);
        `CHK(r, ccrl_pkg::RESP_SLVERR)
        for (int i = 0; i < 5; i++)
        begin
            for (int en = 0; en < 2; en++)
            begin
                host.wr(ccrl_pkg::CTRL_ADDR, 32'h0000_0040 | 32'(en << (fl[i] + 1)), r);
                pulse(ev[i], 1);
                host.rd(ccrl_pkg::IRQ_ADDR, d, r);
                `CHK(d, 32'h0000_00E0 | 32'(en << fl[i]))
                `CHK(irq_out, 1'(en))
                host.wr(ccrl_pkg::IRQ_ADDR, 32'h0000_000F, r);
            end
        end
        host.wr(ccrl_pkg::CTRL_ADDR, 32'h0000_0048, r);
        fifo_start <= 8'($urandom) | 8'h01;
        evt[1] <= 1'b1;
        repeat (3) @(posedge ref_clk);
        evt[1] <= 1'b0;
        @(negedge ref_clk);
        `CHK(reset_mode, 1'b1)
        `CHK(rd_ptr, fifo_start)
        host.rd(ccrl_pkg::IRQ_ADDR, d, r);
        `CHK(d[2], 1'b1)
        host.wr(ccrl_pkg::CTRL_ADDR, 32'h0000_0040, r);
        pulse(0, 1407);
        `CHK(bus_on, 1'b0)
        pulse(0, 1);
        `CHK(bus_on, 1'b1)
        @(posedge ref_clk);
        rstn <= 1'b0;
        @(posedge ref_clk);
        rstn <= 1'b1;
        `CHK(rd_ptr, 8'h00)
        host.rd(ccrl_pkg::CTRL_ADDR, d, r);
        `CHK(d, 32'h0000_0061)
        finish_test();
    end
endmodule // tb
